/* byte_cpu_rotate_sub_exchange_test.sv */
// testbench: directed scenarios for the execution slice
`timescale 1ns/1ps
module byte_cpu_rotate_sub_exchange_test;
  logic clk, busy, unhandled, mem_we_q, bit_we_q, un, we, bw;
  logic rst_n = 0, instr_valid = 0, load = 0;
  logic [7:0] opcode = 0, operand = 0, load_data = 0, src_data;
  logic [7:0] acc_q, psw_q, mem_wdata_q, bit_addr_q, wd, ba;
  logic [7:0] ea = 0, ep = 0;
  logic [15:0] pc_q, epc = 0;
  int n_fail = 0, checks = 0;
  exec_slice exec_slice_inst (.clk(clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .opcode(opcode), .operand(operand),
    .src_data(src_data), .busy(busy), .unhandled(unhandled),
    .acc_q(acc_q), .psw_q(psw_q), .pc_q(pc_q), .mem_we_q(mem_we_q),
    .mem_wdata_q(mem_wdata_q), .bit_we_q(bit_we_q),
    .bit_addr_q(bit_addr_q));
  data_mem_model data_mem_model_inst (.clk(clk), .load(load),
    .load_data(load_data), .we(mem_we_q), .wdata(mem_wdata_q),
    .rdata(src_data));
  // ----
  // clock, compare and closing
  // ----
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one opcode for one edge; strobes captured the cycle after
  task automatic op(input logic [7:0] o, r, m, input int n);
    @(negedge clk);
    instr_valid = 1;
    opcode = o;
    operand = r;
    load = 1;
    load_data = m;
    #1 un = unhandled;
    @(negedge clk);
    instr_valid = 0;
    load = 0;
    {we, wd, bw, ba} = {mem_we_q, mem_wdata_q, bit_we_q, bit_addr_q};
    epc = epc + 16'(n);
  endtask
  // borrow reference: carry, nibble borrow, range flag, difference
  function automatic logic [10:0] sref(input logic [7:0] a, b, input c);
    logic [8:0] d;
    logic [4:0] l;
    logic [7:0] h;
    d = {1'b0, a} - {1'b0, b} - 9'(c);
    l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c);
    h = {1'b0, a[6:0]} - {1'b0, b[6:0]} - 8'(c);
    return {d[8], l[4], h[7] ^ d[8], d[7:0]};
  endfunction
  // ----
  // scenarios
  // ----
  task automatic t_subtract_borrow_op();
    logic [7:0] so[4] = '{8'h9A, 8'h95, 8'h97, 8'h94};
    logic [7:0] av[4] = '{8'hC9, 8'h00, 8'h80, 8'h7F};
    logic [7:0] bv[4] = '{8'h54, 8'h01, 8'h01, 8'hFF};
    logic [10:0] r;
    logic im;
    op(8'hD3, 0, 0, 1); // carry known before the chain
    ep[7] = 1;
    chk(psw_q, ep);
    for (int i = 0; i < 4; i++) begin
      im = so[i] == 8'h94;
      op(8'hC8, 0, av[i], 1);
      op(so[i], im ? bv[i] : ~bv[i], im ? ~bv[i] : bv[i],
         so[i][7:1] == 7'h4A ? 2 : 1);
      r = sref(av[i], bv[i], ep[7]);
      ep = {r[10:9], 3'b000, r[8], 2'b00};
      ea = r[7:0];
      chk(acc_q, ea);
      chk(psw_q, ep);
    end
  endtask
  task automatic t_rot();
    op(8'h23, 0, 0, 1);
    ea = {ea[6:0], ea[7]};
    chk({acc_q, psw_q}, {ea, ep});
    op(8'h33, 0, 0, 1);
    {ep[7], ea} = {ea, ep[7]};
    chk({acc_q, psw_q}, {ea, ep});
    op(8'h03, 0, 0, 1);
    ea = {ea[0], ea[7:1]};
    chk({acc_q, psw_q}, {ea, ep});
    op(8'h13, 0, 0, 1);
    {ea, ep[7]} = {ep[7], ea};
    chk({acc_q, psw_q}, {ea, ep});
    op(8'hC4, 0, 0, 1);
    ea = {ea[3:0], ea[7:4]};
    chk({acc_q, psw_q}, {ea, ep});
  endtask
  task automatic t_trade();
    logic [7:0] to[3] = '{8'hC9, 8'hC5, 8'hC7};
    for (int i = 0; i < 3; i++) begin
      op(to[i], 8'h30, 8'h75 ^ 8'(i), to[i] == 8'hC5 ? 2 : 1);
      chk({acc_q, we, wd}, {8'h75 ^ 8'(i), 1'b1, ea});
      @(negedge clk);
      chk({mem_we_q, src_data}, {1'b0, ea});
      ea = 8'h75 ^ 8'(i);
    end
    op(8'hC8, 0, 8'h36, 1);
    op(8'hD6, 0, 8'h75, 1);
    ea = 8'h35;
    chk({acc_q, we, wd}, {ea, 1'b1, 8'h76});
    chk(psw_q, ep);
    op(8'hD2, 8'h91, 0, 2);
    chk({bw, ba, psw_q}, {1'b1, 8'h91, ep});
  endtask
  // a request held during the second branch cycle must be ignored
  task automatic t_branch();
    logic [7:0] rv[4] = '{8'h21, 8'hFE, 8'h80, 8'h7F};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      instr_valid = 1;
      opcode = 8'h80;
      operand = rv[i];
      @(negedge clk);
      opcode = 8'h23;
      chk(busy, 1);
      @(negedge clk);
      instr_valid = 0;
      epc = epc + 16'h0002 + {{8{rv[i][7]}}, rv[i]};
      chk({busy, pc_q, acc_q}, {1'b0, epc, ea});
    end
    op(8'h00, 0, 0, 0);
    chk({un, we, bw}, 3'b100);
    chk({acc_q, psw_q, pc_q}, {ea, ep, epc});
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    t_subtract_borrow_op();
    t_rot();
    t_trade();
    t_branch();
    stop_test();
  end
  // watchdog: the run needs well under 300 cycles
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule

/* data_mem_model.sv */
// model: operand byte store on the fetch side of the slice
`timescale 1ns/1ps
module data_mem_model (
  // clock
  input wire logic clk,
  // bench preload
  input wire logic load,
  input wire logic [7:0] load_data,
  // slice write-back
  input wire logic we,
  input wire logic [7:0] wdata,
  // byte seen by the slice
  output logic [7:0] rdata
);
  logic [7:0] mem_q = 8'h00;
  // preload shows at once so fetch presents it with the opcode
  assign rdata = load ? load_data : mem_q;
  // write-back wins, the slice owns the byte last
  always @(posedge clk) begin
    if (we) mem_q <= wdata;
    else if (load) mem_q <= load_data;
  end
endmodule

/* exec_pkg.sv */
// package: opcodes, flag positions, timing counts for the execution slice
package exec_pkg;
  // opcode encodings
  localparam logic [7:0] OP_ROT_LEFT = 8'h23;
  localparam logic [7:0] OP_ROT_LEFT_CARRY = 8'h33;
  localparam logic [7:0] OP_ROT_RIGHT = 8'h03;
  localparam logic [7:0] OP_ROT_RIGHT_CARRY = 8'h13;
  localparam logic [7:0] OP_SET_CARRY = 8'hD3;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_SHORT_BR = 8'h80;
  localparam logic [7:0] OP_SUB_IMM = 8'h94;
  localparam logic [7:0] OP_SUB_DIR = 8'h95;
  localparam logic [6:0] OP_SUB_IND = 7'h4B;
  localparam logic [4:0] OP_SUB_REG = 5'h13;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_TRADE_DIR = 8'hC5;
  localparam logic [6:0] OP_TRADE_IND = 7'h63;
  localparam logic [4:0] OP_TRADE_REG = 5'h19;
  localparam logic [6:0] OP_DIGIT_IND = 7'h6B;
  // flag bit positions within the status byte
  localparam int FLAG_CY = 7;
  localparam int FLAG_NIB = 6;
  localparam int FLAG_RANGE = 2;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // program counter step for a two-byte instruction
  localparam logic [15:0] PC_TWO = 16'h0002;
  // execution cycles of the short branch
  localparam logic [1:0] BRANCH_CYCLES = 2'h2;
endpackage

/* exec_slice.sv */
// module: execution datapath for rotates, set-bit, branch, subtract, swaps
`timescale 1ns/1ps
module exec_slice (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // decoded instruction from fetch
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  // operand value read by fetch (register, direct or indirect byte)
  input wire logic [7:0] src_data,
  // execution status
  output logic busy,
  output logic unhandled,
  // architectural state
  output logic [7:0] acc_q,
  output logic [7:0] psw_q,
  output logic [15:0] pc_q,
  // data memory byte write
  output logic mem_we_q,
  output logic [7:0] mem_wdata_q,
  // addressable bit write
  output logic bit_we_q,
  output logic [7:0] bit_addr_q
);
  // ------------------------------------------------------------
  // opcode decode
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BRANCH = 2'b10
  } br_state_t;

  br_state_t state_q;
  logic [15:0] br_target_q;
  logic [1:0] br_cnt_q;
  logic is_rl, is_rlc, is_rr, is_rrc, is_setc, is_setbit, is_br;
  logic is_sub, is_swap, is_xch, is_acc_digit_trade_op, known, go;
  logic [15:0] rel_ext;
  logic [15:0] pc_next;

  // a new instruction is accepted only when no branch is in flight
  assign go = instr_valid && (state_q == ST_IDLE);
  assign busy = (state_q == ST_BRANCH);

  always_comb begin
    is_rl = (opcode == exec_pkg::OP_ROT_LEFT);
    is_rlc = (opcode == exec_pkg::OP_ROT_LEFT_CARRY);
    is_rr = (opcode == exec_pkg::OP_ROT_RIGHT);
    is_rrc = (opcode == exec_pkg::OP_ROT_RIGHT_CARRY);
    is_setc = (opcode == exec_pkg::OP_SET_CARRY);
    is_setbit = (opcode == exec_pkg::OP_SET_BIT);
    is_br = (opcode == exec_pkg::OP_SHORT_BR);
    is_sub = (opcode == exec_pkg::OP_SUB_IMM) ||
             (opcode == exec_pkg::OP_SUB_DIR) ||
             (opcode[7:1] == exec_pkg::OP_SUB_IND) ||
             (opcode[7:3] == exec_pkg::OP_SUB_REG);
    is_swap = (opcode == exec_pkg::OP_SWAP);
    is_xch = (opcode == exec_pkg::OP_TRADE_DIR) ||
             (opcode[7:1] == exec_pkg::OP_TRADE_IND) ||
             (opcode[7:3] == exec_pkg::OP_TRADE_REG);
    is_acc_digit_trade_op = (opcode[7:1] == exec_pkg::OP_DIGIT_IND);
    known = is_rl | is_rlc | is_rr | is_rrc | is_setc | is_setbit |
            is_br | is_sub | is_swap | is_xch | is_acc_digit_trade_op;
  end

  // anything outside this slice is flagged for the rest of the core
  assign unhandled = go && !known;

  // ------------------------------------------------------------
  // subtractor
  // ------------------------------------------------------------
  sub_flags_if sbus ();

  // immediate form takes the operand byte, others the fetched source
  assign sbus.minuend = acc_q;
  assign sbus.subtrahend = (opcode == exec_pkg::OP_SUB_IMM) ?
                           operand : src_data;
  assign sbus.borrow_in = psw_q[exec_pkg::FLAG_CY];

  sub_borrow_unit u_sub (
    .s (sbus)
  );

  // ------------------------------------------------------------
  // accumulator
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= exec_pkg::ACC_RESET;
    end else if (go) begin
      case (1'b1)
        is_rl: acc_q <= {acc_q[6:0], acc_q[7]};
        is_rlc: acc_q <= {acc_q[6:0], psw_q[exec_pkg::FLAG_CY]};
        is_rr: acc_q <= {acc_q[0], acc_q[7:1]};
        is_rrc: acc_q <= {psw_q[exec_pkg::FLAG_CY], acc_q[7:1]};
        is_sub: acc_q <= sbus.diff;
        is_swap: acc_q <= {acc_q[3:0], acc_q[7:4]};
        is_xch: acc_q <= src_data;
        is_acc_digit_trade_op: acc_q <= {acc_q[7:4], src_data[3:0]};
        default: acc_q <= acc_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // flags: only carry rotates, set carry and subtract touch them
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psw_q <= exec_pkg::PSW_RESET;
    end else if (go) begin
      if (is_rlc) begin
        psw_q[exec_pkg::FLAG_CY] <= acc_q[7];
      end else if (is_rrc) begin
        psw_q[exec_pkg::FLAG_CY] <= acc_q[0];
      end else if (is_setc) begin
        psw_q[exec_pkg::FLAG_CY] <= 1'b1;
      end else if (is_sub) begin
        psw_q[exec_pkg::FLAG_CY] <= sbus.cy;
        psw_q[exec_pkg::FLAG_NIB] <= sbus.ac;
        psw_q[exec_pkg::FLAG_RANGE] <= sbus.ov;
      end
    end
  end

  // ------------------------------------------------------------
  // memory and bit writes, one-cycle strobes
  // ------------------------------------------------------------
  // byte trade stores whole old accumulator, digit trade only low nibble
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we_q <= 1'b0;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_we_q <= go && (is_xch || is_acc_digit_trade_op);
      if (go && is_xch) begin
        mem_wdata_q <= acc_q;
      end else if (go && is_acc_digit_trade_op) begin
        mem_wdata_q <= {src_data[7:4], acc_q[3:0]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_we_q <= 1'b0;
      bit_addr_q <= 8'h00;
    end else begin
      bit_we_q <= go && is_setbit;
      if (go && is_setbit) begin
        bit_addr_q <= operand;
      end
    end
  end

  // ------------------------------------------------------------
  // program counter and short branch
  // ------------------------------------------------------------
  // pc_q holds the address of the instruction now presented
  assign rel_ext = {{8{operand[7]}}, operand};
  assign pc_next = pc_q + exec_pkg::PC_TWO + rel_ext;

  // branch holds off new work for its second cycle, then loads pc
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      br_target_q <= exec_pkg::PC_RESET;
      br_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go && is_br) begin
            state_q <= ST_BRANCH;
            br_target_q <= pc_next;
            br_cnt_q <= exec_pkg::BRANCH_CYCLES - 2'h1;
          end
        end
        ST_BRANCH: begin
          br_cnt_q <= br_cnt_q - 2'h1;
          if (br_cnt_q == 2'h1) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // non-branch ops in this slice advance pc by their length;
  // unhandled opcodes leave pc for the rest of the core to move
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= exec_pkg::PC_RESET;
    end else if (state_q == ST_BRANCH && br_cnt_q == 2'h1) begin
      pc_q <= br_target_q;
    end else if (go && known && !is_br) begin
      if (is_setbit || opcode == exec_pkg::OP_SUB_IMM ||
          opcode == exec_pkg::OP_SUB_DIR ||
          opcode == exec_pkg::OP_TRADE_DIR) begin
        pc_q <= pc_q + exec_pkg::PC_TWO;
      end else begin
        pc_q <= pc_q + 16'h0001;
      end
    end
  end
endmodule

/* exec_slice_assertions.sv */
// checker: port relations of the execution slice
`timescale 1ns/1ps
module exec_slice_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction in
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic [7:0] src_data,
  // results out
  input wire logic busy,
  input wire logic unhandled,
  input wire logic [7:0] acc_q,
  input wire logic [7:0] psw_q,
  input wire logic [15:0] pc_q,
  input wire logic mem_we_q,
  input wire logic [7:0] mem_wdata_q,
  input wire logic bit_we_q,
  input wire logic [7:0] bit_addr_q
);
  // ----
  // properties on the core clock
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic tk;
  // busy refuses requests, so only this counts as taken
  assign tk = instr_valid & ~busy;
  chk_rotl_wrap: assert property (tk && opcode == 8'h23 |=>
    acc_q == {$past(acc_q[6:0]), $past(acc_q[7])} && $stable(psw_q))
    else $error("rotate left wrong");
  chk_rotl_ring: assert property (tk && opcode == 8'h33 |=>
    acc_q == {$past(acc_q[6:0]), $past(psw_q[7])}
    && psw_q == {$past(acc_q[7]), $past(psw_q[6:0])})
    else $error("rotate left carry wrong");
  chk_rotr_wrap: assert property (tk && opcode == 8'h03 |=>
    acc_q == {$past(acc_q[0]), $past(acc_q[7:1])} && $stable(psw_q))
    else $error("rotate right wrong");
  chk_rotr_ring: assert property (tk && opcode == 8'h13 |=>
    acc_q == {$past(psw_q[7]), $past(acc_q[7:1])}
    && psw_q == {$past(acc_q[0]), $past(psw_q[6:0])})
    else $error("rotate right carry wrong");
  chk_bit_set: assert property (tk && opcode == 8'hD2 |=>
    bit_we_q && bit_addr_q == $past(operand) ##1 !bit_we_q)
    else $error("bit set strobe wrong");
  chk_branch_target: assert property (tk && opcode == 8'h80 |=>
    busy ##1 !busy && pc_q == $past(pc_q, 2) + 16'h0002
    + {{8{$past(operand[7], 2)}}, $past(operand, 2)})
    else $error("branch target wrong");
  chk_digit_trade: assert property (tk && opcode[7:1] == 7'h6B |=>
    acc_q == {$past(acc_q[7:4]), $past(src_data[3:0])} && mem_we_q
    && mem_wdata_q == {$past(src_data[7:4]), $past(acc_q[3:0])}
    && $stable(psw_q)) else $error("digit trade wrong");
  chk_other_hold: assert property (unhandled && instr_valid |=>
    $stable(acc_q) && $stable(psw_q) && $stable(pc_q) && !mem_we_q
    && !bit_we_q) else $error("foreign opcode changed state");
  cover property (tk && opcode == 8'h80);
  cover property (tk && opcode[7:3] == 5'h13);
  cover property (tk && opcode[7:1] == 7'h6B);
endmodule
bind exec_slice exec_slice_checker exec_slice_checker_inst (.clk(clk),
  .rst_n(rst_n), .instr_valid(instr_valid), .opcode(opcode),
  .operand(operand), .src_data(src_data), .busy(busy),
  .unhandled(unhandled), .acc_q(acc_q), .psw_q(psw_q), .pc_q(pc_q),
  .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .bit_we_q(bit_we_q),
  .bit_addr_q(bit_addr_q));

/* sub_borrow_unit.sv */
// module: 8-bit subtract with borrow and its flag outputs
`timescale 1ns/1ps
module sub_borrow_unit (
  // operand and result bundle
  sub_flags_if.calc s
);
  logic [4:0] low;
  logic [3:0] mid;
  logic [1:0] top;

  // split into nibble, bits 6-4 and bit 7 to expose each borrow
  always_comb begin
    low = {1'b0, s.minuend[3:0]} - {1'b0, s.subtrahend[3:0]}
          - {4'h0, s.borrow_in};
    mid = {1'b0, s.minuend[6:4]} - {1'b0, s.subtrahend[6:4]}
          - {3'h0, low[4]};
    top = {1'b0, s.minuend[7]} - {1'b0, s.subtrahend[7]}
          - {1'b0, mid[3]};
    s.diff = {top[0], mid[2:0], low[3:0]};
    s.cy = top[1];
    s.ac = low[4];
    s.ov = mid[3] ^ top[1];
  end
endmodule

/* sub_flags_if.sv */
// interface: operands and results of the borrow subtractor
`timescale 1ns/1ps
interface sub_flags_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic borrow_in;
  logic [7:0] diff;
  logic cy;
  logic ac;
  logic ov;
  modport calc (input minuend, subtrahend, borrow_in,
                output diff, cy, ac, ov);
  modport user (output minuend, subtrahend, borrow_in,
                input diff, cy, ac, ov);
endinterface
